/* File: bgld_regs.sv */
// configuration registers: pin data, direction and link diagnostics
`timescale 1ns/1ps
`include "bgld_defs.svh"
module bgld_regs #(
  parameter int NPINS = 5
) (
  // clock and resets
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_link_rst,
  input  wire logic             i_global_reset_input,
  // configuration access, dword offset
  input  wire logic             i_cfg_wr,
  input  wire logic             i_cfg_rd,
  input  wire logic [7:0]       i_cfg_addr,
  input  wire logic [31:0]      i_cfg_wdata,
  input  wire logic [3:0]       i_cfg_be,
  output logic      [31:0]      o_cfg_rdata,
  output logic                  o_cfg_rvalid,
  // captured identity and link state
  input  wire logic [7:0]       i_bus_num,
  input  wire logic [4:0]       i_dev_num,
  input  wire logic             i_common_clock,
  input  wire logic             i_link_idle,
  input  wire logic             i_downstream_bus_reset_request,
  // alternate function enables per pin
  input  wire logic [NPINS-1:0] i_alt_en,
  // pins
  input  wire logic [NPINS-1:0] i_pin,
  output logic      [NPINS-1:0] o_pin,
  output logic      [NPINS-1:0] o_pin_oe,
  // controls
  output logic                  o_advisory_error_disable,
  output logic                  o_cfg_mem_access,
  output logic                  o_clock_request,
  output logic      [2:0]       o_advertised_l1_exit_latency,
  output logic                  o_downstream_reset,
  output logic                  o_l1_entry
);
  logic             rst_all;
  logic [NPINS-1:0] pin_s;
  logic [NPINS-1:0] dir_q;
  logic [NPINS-1:0] dir_d;
  logic [NPINS-1:0] out_q;
  logic [NPINS-1:0] out_d;
  logic [NPINS-1:0] oe_q;
  logic [31:0]      d0_q;
  logic [31:0]      d0_d;
  logic [31:0]      d1_q;
  logic [31:0]      d1_d;
  logic [31:0]      rd_q;
  logic [31:0]      rd_d;
  logic             rv_q;
  logic [7:0]       bus_q;
  logic [4:0]       dev_q;
  logic [7:0]       bus_d;
  logic [4:0]       dev_d;
  logic             adv_q;
  logic             mem_q;
  logic             clk_q;
  logic [2:0]       lat_q;
  logic [2:0]       lat_d;
  logic             downstream_bus_reset_request_q;
  logic             entry;
  logic [NPINS-1:0] alt_m;

  // pin 2 has no alternate function, so its enable is never honoured
  assign alt_m = i_alt_en & ~(NPINS'(1) << 2);

  // any of the three reset sources returns the bank to its reset values
  assign rst_all = i_rst | i_link_rst | i_global_reset_input;

  // pins cross in from outside before anything reads them
  bgld_sync #(.WIDTH(NPINS)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (rst_all),
    .i_async   (i_pin),
    .o_sync    (pin_s)
  );

  bgld_idle_timer u_timer (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (rst_all),
    .i_link_idle (i_link_idle),
    .i_limit     (d1_q[`BGLD_TMR_HI:`BGLD_TMR_LO]),
    .o_entry     (entry)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
    merge = (old & ~m) | (wd & m);
  endfunction

  // data register sits in the upper half of the b4 dword
  function automatic logic [NPINS-1:0] pin_hit(input logic [3:0] be);
    pin_hit = {NPINS{be[2]}};
  endfunction

  always_comb begin
    dir_d = dir_q;
    out_d = out_q;
    d0_d  = d0_q;
    d1_d  = d1_q;
    if (i_cfg_wr) begin
      case (i_cfg_addr)
        `BGLD_OFF_DIR: begin
          if (i_cfg_be[0]) begin
            dir_d = i_cfg_wdata[NPINS-1:0];
          end
          // only output pins without alternate use accept data
          out_d = (out_q & ~(pin_hit(i_cfg_be) & dir_q & ~alt_m)) |
                  (i_cfg_wdata[16 +: NPINS] &
                   pin_hit(i_cfg_be) & dir_q & ~alt_m);
        end
        `BGLD_OFF_DIAG0: begin
          d0_d = merge(d0_q, i_cfg_wdata, i_cfg_be, `BGLD_DIAG0_WMASK);
        end
        `BGLD_OFF_DIAG1: begin
          d1_d = merge(d1_q, i_cfg_wdata, i_cfg_be, `BGLD_DIAG1_WMASK);
        end
        default: begin
          dir_d = dir_q;
        end
      endcase
    end
  end

  // captured numbers are kept read-only to software
  always_comb begin
    bus_d = i_bus_num;
    dev_d = i_dev_num;
    lat_d = i_common_clock ?
            d1_q[`BGLD_LAT_SHR_HI:`BGLD_LAT_SHR_LO] :
            d1_q[`BGLD_LAT_SEP_HI:`BGLD_LAT_SEP_LO];
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (i_cfg_addr)
      `BGLD_OFF_DIR: begin
        rd_d[NPINS-1:0] = dir_q;
        // input pins show the sensed level, upper bits zero
        rd_d[16 +: NPINS] = (dir_q & ~alt_m & out_q) |
                            (~(dir_q & ~alt_m) & pin_s);
      end
      `BGLD_OFF_DIAG0: begin
        rd_d = (d0_q & `BGLD_DIAG0_WMASK) |
               {bus_q, dev_q, 19'h0_0000};
      end
      `BGLD_OFF_DIAG1: begin
        rd_d = d1_q & `BGLD_DIAG1_WMASK;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      dir_q  <= '0;
      out_q  <= '0;
      oe_q   <= '0;
      d0_q   <= `BGLD_DIAG0_RESET;
      d1_q   <= `BGLD_DIAG1_RESET;
      rd_q   <= 32'h0000_0000;
      rv_q   <= 1'b0;
      bus_q  <= 8'h00;
      dev_q  <= 5'h00;
      adv_q  <= 1'b0;
      mem_q  <= 1'b0;
      clk_q  <= 1'b1;
      lat_q  <= 3'h4;
      downstream_bus_reset_request_q <= 1'b0;
    end else begin
      dir_q  <= dir_d;
      out_q  <= out_d;
      // alternate-function pins are handed to their function logic
      oe_q   <= dir_q & ~alt_m;
      d0_q   <= d0_d;
      d1_q   <= d1_d;
      rd_q   <= rd_d;
      rv_q   <= i_cfg_rd;
      bus_q  <= bus_d;
      dev_q  <= dev_d;
      adv_q  <= d0_q[`BGLD_BIT_ADV_DIS];
      mem_q  <= d0_q[`BGLD_BIT_CFG_MEM];
      clk_q  <= d0_q[`BGLD_BIT_CLK_HOLD] | (entry == 1'b0);
      lat_q  <= lat_d;
      downstream_bus_reset_request_q <= i_downstream_bus_reset_request &
                ~d1_q[`BGLD_BIT_RST_SUPP];
    end
  end

  logic entry_q;
  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      entry_q <= 1'b0;
    end else begin
      entry_q <= entry;
    end
  end

  assign o_cfg_rdata                  = rd_q;
  assign o_cfg_rvalid                 = rv_q;
  assign o_pin                        = out_q;
  assign o_pin_oe                     = oe_q;
  assign o_advisory_error_disable     = adv_q;
  assign o_cfg_mem_access             = mem_q;
  assign o_clock_request              = clk_q;
  assign o_advertised_l1_exit_latency = lat_q;
  assign o_downstream_reset           = downstream_bus_reset_request_q;
  assign o_l1_entry                   = entry_q;

  a_reset_clkreq: assert property (@(posedge i_clk_sys)
    rst_all |=> o_clock_request)
    else $error("clock request not held after reset");
  a_clkreq_hold: assert property (@(posedge i_clk_sys)
    disable iff (rst_all) d0_q[0] |=> o_clock_request)
    else $error("clock request dropped while hold bit set");
  a_downstream_bus_reset_request_mask: assert property (@(posedge i_clk_sys)
    disable iff (rst_all) d1_q[10] |=> !o_downstream_reset)
    else $error("downstream reset not suppressed");
  a_downstream_bus_reset_request_pass: assert property (@(posedge i_clk_sys)
    disable iff (rst_all)
    (!d1_q[10] && i_downstream_bus_reset_request) |=> o_downstream_reset)
    else $error("downstream reset request lost");
  a_lat_select: assert property (@(posedge i_clk_sys)
    disable iff (rst_all)
    i_common_clock |=> o_advertised_l1_exit_latency == $past(d1_q[20:18]))
    else $error("shared clock latency not advertised");
  a_lat_sep: assert property (@(posedge i_clk_sys)
    disable iff (rst_all)
    !i_common_clock |=> o_advertised_l1_exit_latency == $past(d1_q[17:15]))
    else $error("separate clock latency not advertised");
  a_data_upper: assert property (@(posedge i_clk_sys)
    disable iff (rst_all) o_cfg_rvalid |-> o_cfg_rdata[31:21] == 11'h000 ||
    $past(i_cfg_addr) != 8'hb4)
    else $error("data register upper bits not zero");
  a_input_ignore: assert property (@(posedge i_clk_sys)
    disable iff (rst_all) (i_cfg_wr && i_cfg_addr == 8'hb4 && !dir_q[2])
    |=> o_pin[2] == $past(o_pin[2]))
    else $error("write changed input pin value");
  a_diag0_rsvd: assert property (@(posedge i_clk_sys)
    disable iff (rst_all)
    (o_cfg_rvalid && $past(i_cfg_addr) == 8'hc0) |-> o_cfg_rdata[17:16]
    == 2'b00 && o_cfg_rdata[13:12] == 2'b00 && o_cfg_rdata[6:3] == 4'h0)
    else $error("diag0 reserved bits not zero");
endmodule

/* File: bgld_defs.svh */
// constants for the pin data and link diagnostic register bank
`ifndef BGLD_DEFS_SVH
`define BGLD_DEFS_SVH
`define BGLD_OFF_DIR        8'hb4
`define BGLD_OFF_DATA       8'hb6
`define BGLD_OFF_DIAG0      8'hc0
`define BGLD_OFF_DIAG1      8'hc4
`define BGLD_DIAG0_RESET    32'h0000_0001
`define BGLD_DIAG1_RESET    32'h0012_0108
`define BGLD_DIAG0_WMASK    32'h0004_cf87
`define BGLD_DIAG1_WMASK    32'h001f_ffff
`define BGLD_BIT_ADV_DIS    18
`define BGLD_BIT_CFG_MEM    2
`define BGLD_BIT_CLK_HOLD   0
`define BGLD_BIT_RST_SUPP   10
`define BGLD_LAT_SHR_HI     20
`define BGLD_LAT_SHR_LO     18
`define BGLD_LAT_SEP_HI     17
`define BGLD_LAT_SEP_LO     15
`define BGLD_TMR_HI         9
`define BGLD_TMR_LO         6
`define BGLD_TICK_NS        512
`define BGLD_CLK_NS         40
`define BGLD_TICK_CYC       ((`BGLD_TICK_NS + `BGLD_CLK_NS - 1) / `BGLD_CLK_NS)
`endif

/* File: bgld_pkg.sv */
// types for the pin data and link diagnostic register bank
package bgld_pkg;
  typedef enum logic [1:0] {
    BGLD_IDLE  = 2'b01,
    BGLD_COUNT = 2'b10
  } bgld_idle_state_type;
endpackage

/* File: bgld_sync.sv */
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module bgld_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule

/* File: bgld_idle_timer.sv */
// idle timer that requests L1 entry after n ticks of 512 ns rounded up to whole clocks (13 clocks, 520 ns)
`timescale 1ns/1ps
`include "bgld_defs.svh"
module bgld_idle_timer #(
  parameter int TICK_CYC = `BGLD_TICK_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_link_idle,
  input  wire logic [3:0] i_limit,
  output logic            o_entry
);
  bgld_pkg::bgld_idle_state_type st_q;
  bgld_pkg::bgld_idle_state_type st_d;
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic [3:0] ticks_q;
  logic [3:0] ticks_d;
  logic       entry_q;
  logic       entry_d;
  logic       tick;

  assign tick = (pre_q == 8'(TICK_CYC - 1));

  always_comb begin
    st_d    = st_q;
    pre_d   = pre_q;
    ticks_d = ticks_q;
    entry_d = 1'b0;
    case (st_q)
      bgld_pkg::BGLD_IDLE: begin
        pre_d   = 8'h00;
        ticks_d = 4'h0;
        if (i_link_idle) begin
          st_d = bgld_pkg::BGLD_COUNT;
        end
      end
      bgld_pkg::BGLD_COUNT: begin
        if (!i_link_idle) begin
          st_d = bgld_pkg::BGLD_IDLE;
        end else if (tick) begin
          pre_d = 8'h00;
          if (ticks_q + 4'h1 >= i_limit) begin
            entry_d = 1'b1;
            st_d    = bgld_pkg::BGLD_IDLE;
          end else begin
            ticks_d = ticks_q + 4'h1;
          end
        end else begin
          pre_d = pre_q + 8'h01;
        end
      end
      default: st_d = bgld_pkg::BGLD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q    <= bgld_pkg::BGLD_IDLE;
      pre_q   <= 8'h00;
      ticks_q <= 4'h0;
      entry_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      pre_q   <= pre_d;
      ticks_q <= ticks_d;
      entry_q <= entry_d;
    end
  end
  assign o_entry = entry_q;
endmodule

/* File: bgld_host.sv */
// upstream host model issuing configuration accesses to the bank
`timescale 1ns/1ps
`include "bgld_defs.svh"
module bgld_host (
  // clock
  input  wire logic        i_clk_sys,
  // configuration access towards the device
  output logic             o_cfg_wr,
  output logic             o_cfg_rd,
  output logic [7:0]       o_cfg_addr,
  output logic [31:0]      o_cfg_wdata,
  output logic [3:0]       o_cfg_be,
  input  wire logic [31:0] i_cfg_rdata,
  input  wire logic        i_cfg_rvalid
);
  initial begin
    o_cfg_wr    = 1'b0;
    o_cfg_rd    = 1'b0;
    o_cfg_addr  = 8'h00;
    o_cfg_wdata = 32'h0000_0000;
    o_cfg_be    = 4'h0;
  end

  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] be);
    logic [31:0] v;
    v = d;
    if (a == `BGLD_OFF_DIAG0) v = d & ~32'h0000_cf82;
    if (a == `BGLD_OFF_DIAG1) v = d & ~32'h0000_7800;
    @(posedge i_clk_sys);
    o_cfg_wr    <= 1'b1;
    o_cfg_addr  <= a;
    o_cfg_wdata <= v;
    o_cfg_be    <= be;
    @(posedge i_clk_sys);
    o_cfg_wr    <= 1'b0;
    // data left on the bus is not meaningful once the write is taken
    o_cfg_wdata <= ~v;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    logic got;
    got = 1'b0;
    d   = 'x;
    @(posedge i_clk_sys);
    o_cfg_rd   <= 1'b1;
    o_cfg_addr <= a;
    o_cfg_be   <= 4'hf;
    @(posedge i_clk_sys);
    o_cfg_rd <= 1'b0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge i_clk_sys);
      if (i_cfg_rvalid === 1'b1) begin
        d   = i_cfg_rdata;
        got = 1'b1;
      end
    end
  endtask
endmodule

/* File: tb_bgld_regs.sv */
// testbench for the pin data and link diagnostic register bank
`timescale 1ns/1ps
`include "bgld_defs.svh"
module tb_bgld_regs;
  logic        clk, rst, link_rst, global_reset_input, cfg_wr, rd, rvalid;
  logic        common_clk, link_idle, dsr_req, adv_dis, mem_acc;
  logic        clk_req, dsr_out, l1_entry;
  logic [7:0]  addr, bus_num;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic [4:0]  dev_num, alt_en, pin_ext, pin_in, pin_out, pin_oe;
  logic [2:0]  lat;
  int          n_mismatch = 0;
  int          n_tests = 0;

  // wire level: the driving party wins, otherwise the far side's level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);

  bgld_regs bgld_regs_inst (
    .i_clk_sys(clk), .i_rst(rst), .i_link_rst(link_rst),
    .i_global_reset_input(global_reset_input), .i_cfg_wr(cfg_wr), .i_cfg_rd(rd),
    .i_cfg_addr(addr), .i_cfg_wdata(wdata), .i_cfg_be(be),
    .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .i_bus_num(bus_num),
    .i_dev_num(dev_num), .i_common_clock(common_clk),
    .i_link_idle(link_idle), .i_downstream_bus_reset_request(dsr_req),
    .i_alt_en(alt_en), .i_pin(pin_in), .o_pin(pin_out),
    .o_pin_oe(pin_oe), .o_advisory_error_disable(adv_dis),
    .o_cfg_mem_access(mem_acc), .o_clock_request(clk_req),
    .o_advertised_l1_exit_latency(lat), .o_downstream_reset(dsr_out),
    .o_l1_entry(l1_entry));

  bgld_host bgld_host_inst (
    .i_clk_sys(clk), .o_cfg_wr(cfg_wr), .o_cfg_rd(rd), .o_cfg_addr(addr),
    .o_cfg_wdata(wdata), .o_cfg_be(be), .i_cfg_rdata(rdata),
    .i_cfg_rvalid(rvalid));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] d;
    bgld_host_inst.cfg_read(a, d);
    chk_word(d & m, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    bgld_host_inst.cfg_write(a, d, b);
    // control outputs trail the register by one cycle
    repeat (2) @(posedge clk);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    int n;
    {rst, link_rst, global_reset_input} = 3'b100;
    {common_clk, link_idle, dsr_req} = 3'b101;
    bus_num = 8'h5a;
    dev_num = 5'h13;
    pin_ext = 5'h15;
    alt_en  = 5'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_bit(clk_req, 1'b1);
    chk_bit(dsr_out, 1'b0);
    chk_word({29'h0, lat}, 32'h0000_0004);
    rd_chk(`BGLD_OFF_DIAG0, '1, 32'h5a98_0001);
    chk_bit(dsr_out, 1'b1);
    rd_chk(`BGLD_OFF_DIAG1, '1, `BGLD_DIAG1_RESET);
    rd_chk(`BGLD_OFF_DIR, '1, 32'h0015_0000);
    rd_chk(8'hd0, '1, 32'h0000_0000); // unmapped offset reads zero
    wr(`BGLD_OFF_DIAG0, 32'hffff_307d, 4'hf);
    rd_chk(`BGLD_OFF_DIAG0, '1, 32'h5a9c_0005);
    chk_bit(adv_dis, 1'b1);
    chk_bit(mem_acc, 1'b1);
    wr(`BGLD_OFF_DIAG1, 32'hffea_8440, 4'hf);
    rd_chk(`BGLD_OFF_DIAG1, '1, 32'h000a_8440);
    chk_word({29'h0, lat}, 32'h0000_0002);
    chk_bit(dsr_out, 1'b0);
    common_clk <= 1'b0;
    repeat (3) @(posedge clk);
    chk_word({29'h0, lat}, 32'h0000_0005);
    link_idle <= 1'b1;
    n = 0;
    while (l1_entry !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk_bit(n >= 13 && n <= 40, 1'b1);
    link_idle <= 1'b0;
    // direction first: data lands only on pins already set as outputs
    wr(`BGLD_OFF_DIR, 32'h0000_001f, 4'b0001);
    wr(`BGLD_OFF_DIR, 32'hfff4_ffff, 4'b0101);
    rd_chk(`BGLD_OFF_DIR, '1, 32'h0014_001f);
    chk_word({27'h0, pin_out}, 32'h0000_0014);
    // pin 1 uses its alternate function; pin 2 has none to enable
    alt_en <= 5'h06;
    wr(`BGLD_OFF_DIR, 32'h000b_001e, 4'b0101);
    chk_word({27'h0, pin_out & 5'h1c}, 32'h0000_0008);
    chk_word({27'h0, pin_oe}, 32'h0000_001c);
    rd_chk(`BGLD_OFF_DIR, 32'h001d_001f, 32'h0009_001e);
    for (int k = 0; k < 3; k++) begin
      wr(`BGLD_OFF_DIAG1, 32'h0000_0000, 4'hf);
      wr(`BGLD_OFF_DIR, 32'h0000_001f, 4'hf);
      {global_reset_input, link_rst, rst} <= 3'b001 << k;
      @(posedge clk);
      {global_reset_input, link_rst, rst} <= 3'b000;
      rd_chk(`BGLD_OFF_DIAG1, '1, `BGLD_DIAG1_RESET);
      rd_chk(`BGLD_OFF_DIR, 32'h0000_ffff, 32'h0000_0000);
    end
    conclude();
  end
endmodule
